// ===== verilog/sshp_host_port.sv
// Purpose: serial host port of the sensor, i2c and spi target with register image
// Assumes: ref_clk 40 MHz; sck from host clocks the spi frame logic
// Notes: i2c is oversampled on ref_clk, spi runs on sck itself
// the i2c side only ever pulls data low and leaves the clock pin alone
//
// Overview of operation
// - acts only as target, all i2c speeds
// - chip select high i2c, low spi
// - one low chip select locks out i2c
// - never stretches or pulls the clock low
// - address 111011 plus live select pin
// - i2c write stores address and data pairs
// - i2c read increments until host nack
// - spi mode from clock at select fall
// - 3-wire bit moves data to shared pin
// - sample on rising, drive on falling edge
// - frame from select low to high
// - active low select idles high undriven
// - top control bit is direction, forced one
// - spi write pairs, no increment
// - spi read streams with increment
// - heater stability in bit 4 of 0x2b
`timescale 1ns/100ps
`include "sshp_regs.svh"

module sshp_host_port (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic csb_n,
	input wire logic sck,
	input wire logic sdi_in,
	output logic sdi_out,
	output logic sdi_oe,
	input wire logic sdo_in,
	output logic sdo_out,
	output logic sdo_oe,
	input wire logic [7:0] gas_lsb_in,
	input wire logic heater_stable,
	output logic reg_wr_stb,
	output logic [7:0] reg_wr_addr,
	output logic [7:0] reg_wr_data,
	output logic i2c_enabled,
	output logic spi_locked,
	output logic spi_mode_11,
	output logic three_wire_enable
);

	sshp_pkg::sshp_top_t r_reg;
	sshp_pkg::sshp_top_t r_next;

	// decoded bus conditions
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic addr_hit;
	logic spi_wr_evt;

	// single write port shared by both protocols
	logic we;
	logic [7:0] wa;
	logic [7:0] wd;

	// spi engine outputs
	logic spi_sdi_out;
	logic spi_sdi_oe;
	logic spi_wr_tgl;
	logic [6:0] spi_wr_addr;
	logic [7:0] spi_wr_data;
	logic spi_mode_raw;

	// read decode for the i2c side; 0x2b is built live from the core
	function automatic logic [7:0] sshp_read(
		input logic [7:0] a,
		input sshp_pkg::sshp_img_t img,
		input logic [7:0] gas,
		input logic stab
	);
		logic [7:0] v;
		v = `SSHP_UNMAPPED;
		if (a == `SSHP_REG_GAS_LSB) begin
			v = gas;
			v[`SSHP_HEAT_STAB_BIT] = stab;
		end else if (a[7]) begin
			v = img[a[6:0]];
		end
		return v;
	endfunction : sshp_read

	// next count of a serial byte; wraps in 4 bits like the counter itself
	function automatic logic [3:0] sshp_bit_next(
		input logic [3:0] b
	);
		return 4'(b + `SSHP_BITS_ONE);
	endfunction : sshp_bit_next

	// a byte is complete once its eighth rising clock has been counted
	function automatic logic sshp_byte_full(
		input logic [3:0] b
	);
		return b == `SSHP_BITS_BYTE;
	endfunction : sshp_byte_full

	// one bus bit shifted in at the bottom, msb first as the bus sends it
	function automatic logic [7:0] sshp_shift_in(
		input logic [7:0] s,
		input logic d
	);
		return {s[6:0], d};
	endfunction : sshp_shift_in

	// open drain: pull low only for a zero bit, a one is left to the pull-up
	function automatic logic sshp_pull_low(
		input logic d
	);
		return ~d;
	endfunction : sshp_pull_low

	// 3-wire enable as stored in the image; the spi side and the status both read it
	function automatic logic sshp_tw_of(
		input sshp_pkg::sshp_img_t img
	);
		return img[7'(`SSHP_REG_SPI_CFG)][`SSHP_TW_BIT];
	endfunction : sshp_tw_of

	// sync stages rest at the idle levels of their pins, so release of reset
	// never shows a select low or a clock edge that the host did not make
	function automatic sshp_pkg::sshp_top_t sshp_rst_state();
		sshp_pkg::sshp_top_t s;
		s = '0;
		s.csb_sy = `SSHP_CSB_IDLE;
		s.scl_sy = `SSHP_LINE_IDLE;
		s.sda_sy = `SSHP_LINE_IDLE;
		return s;
	endfunction : sshp_rst_state

	localparam sshp_pkg::sshp_top_t rst_state = sshp_rst_state();

	// spi frame logic on the host clock
	sshp_spi_link u_spi (
		.sck(sck),
		.csb_n(csb_n),
		.reset(reset),
		.sdi_in(sdi_in),
		.tw_en(sshp_tw_of(r_reg.img)),
		.img(r_reg.img),
		.sdi_out(spi_sdi_out),
		.sdi_oe(spi_sdi_oe),
		.sdo_out(sdo_out),
		.sdo_oe(sdo_oe),
		.wr_tgl(spi_wr_tgl),
		.wr_addr(spi_wr_addr),
		.wr_data(spi_wr_data),
		.mode_11(spi_mode_raw)
	);

	// edges taken between second and third sync stages only
	assign scl_rise = r_reg.scl_sy[1] & ~r_reg.scl_sy[2];
	assign scl_fall = ~r_reg.scl_sy[1] & r_reg.scl_sy[2];
	assign start_cond = r_reg.scl_sy[1] & r_reg.scl_sy[2] & r_reg.sda_sy[2] & ~r_reg.sda_sy[1];
	assign stop_cond = r_reg.scl_sy[1] & r_reg.scl_sy[2] & ~r_reg.sda_sy[2] & r_reg.sda_sy[1];

	// low address bit follows the select pin as it is now
	assign addr_hit = r_reg.sh[7:1] == {`SSHP_I2C_ADDR_HI, r_reg.asel_sy[1]};

	// spi write handed over by toggle; data held for a whole byte
	// only the toggle crosses through flops; address and data are settled by then
	assign spi_wr_evt = r_reg.wt_sy[1] ^ r_reg.wt_sy[2];

	// next state of the reference domain
	always_comb begin
		r_next = r_reg;
		we = 1'b0;
		wa = 8'h00;
		wd = 8'h00;
		r_next.wr_stb = 1'b0;

		// two flops on every pin before any decode
		r_next.csb_sy = {r_reg.csb_sy[0], csb_n};
		r_next.scl_sy = {r_reg.scl_sy[1:0], sck};
		r_next.sda_sy = {r_reg.sda_sy[1:0], sdi_in};
		r_next.asel_sy = {r_reg.asel_sy[0], sdo_in};
		r_next.wt_sy = {r_reg.wt_sy[1:0], spi_wr_tgl};
		r_next.mode_sy = {r_reg.mode_sy[0], spi_mode_raw};

		// any low chip select since reset keeps i2c off for good
		// set only, so spi traffic meant for another target is never decoded as i2c
		if (!r_reg.csb_sy[1]) begin
			r_next.lock = 1'b1;
		end
		r_next.i2c_en = r_reg.csb_sy[1] & ~r_reg.lock;

		if (!r_reg.i2c_en) begin
			// spi owns the pins; the i2c sequencer rests
			r_next.st = sshp_pkg::st_idle;
			r_next.sda_oe = 1'b0;
		end else if (start_cond) begin
			// start and repeated start both restart address decode
			r_next.st = sshp_pkg::st_addr;
			r_next.bits = `SSHP_BITS_ZERO;
			r_next.sda_oe = 1'b0;
		end else if (stop_cond) begin
			r_next.st = sshp_pkg::st_idle;
			r_next.sda_oe = 1'b0;
		end else begin
			case (r_reg.st)
				sshp_pkg::st_idle: begin
					r_next.sda_oe = 1'b0;
				end
				sshp_pkg::st_addr: begin
					if (scl_rise) begin
						r_next.sh = sshp_shift_in(r_reg.sh, r_reg.sda_sy[1]);
						r_next.bits = sshp_bit_next(r_reg.bits);
					end else if (scl_fall && sshp_byte_full(r_reg.bits)) begin
						r_next.bits = `SSHP_BITS_ZERO;
						if (addr_hit) begin
							r_next.sda_oe = 1'b1;
							r_next.rw = r_reg.sh[0];
							r_next.st = sshp_pkg::st_addr_ack;
						end else begin
							// another target is addressed; wait for the next start
							r_next.st = sshp_pkg::st_idle;
						end
					end
				end
				sshp_pkg::st_addr_ack: begin
					if (scl_fall) begin
						r_next.bits = `SSHP_BITS_ZERO;
						if (r_reg.rw) begin
							// first read byte leaves from the stored pointer
							r_next.sh = sshp_read(r_reg.ptr, r_reg.img, gas_lsb_in, heater_stable);
							r_next.sda_oe = sshp_pull_low(r_next.sh[7]);
							r_next.st = sshp_pkg::st_tx_byte;
						end else begin
							r_next.sda_oe = 1'b0;
							r_next.pair_data = 1'b0;
							r_next.st = sshp_pkg::st_rx_byte;
						end
					end
				end
				sshp_pkg::st_rx_byte: begin
					if (scl_rise) begin
						r_next.sh = sshp_shift_in(r_reg.sh, r_reg.sda_sy[1]);
						r_next.bits = sshp_bit_next(r_reg.bits);
					end else if (scl_fall && sshp_byte_full(r_reg.bits)) begin
						r_next.bits = `SSHP_BITS_ZERO;
						if (r_reg.pair_data) begin
							// data lands at its own paired address, no increment
							we = 1'b1;
							wa = r_reg.ptr;
							wd = r_reg.sh;
						end else begin
							r_next.ptr = r_reg.sh;
						end
						r_next.pair_data = ~r_reg.pair_data;
						r_next.sda_oe = 1'b1;
						r_next.st = sshp_pkg::st_rx_ack;
					end
				end
				sshp_pkg::st_rx_ack: begin
					if (scl_fall) begin
						r_next.sda_oe = 1'b0;
						r_next.st = sshp_pkg::st_rx_byte;
					end
				end
				sshp_pkg::st_tx_byte: begin
					if (scl_rise) begin
						r_next.bits = sshp_bit_next(r_reg.bits);
					end else if (scl_fall) begin
						if (sshp_byte_full(r_reg.bits)) begin
							// release for the host acknowledge bit
							r_next.sda_oe = 1'b0;
							r_next.ptr = 8'(r_reg.ptr + 8'h01);
							r_next.st = sshp_pkg::st_tx_ack;
						end else begin
							r_next.sh = {r_reg.sh[6:0], 1'b0};
							r_next.sda_oe = sshp_pull_low(r_reg.sh[6]);
						end
					end
				end
				sshp_pkg::st_tx_ack: begin
					if (scl_rise && r_reg.sda_sy[1]) begin
						// host_not_acknowledge ends the stream; stop follows
						r_next.st = sshp_pkg::st_idle;
					end else if (scl_fall) begin
						r_next.bits = `SSHP_BITS_ZERO;
						r_next.sh = sshp_read(r_reg.ptr, r_reg.img, gas_lsb_in, heater_stable);
						r_next.sda_oe = sshp_pull_low(r_next.sh[7]);
						r_next.st = sshp_pkg::st_tx_byte;
					end
				end
				default: begin
					r_next.st = sshp_pkg::st_idle;
					r_next.sda_oe = 1'b0;
				end
			endcase
		end

		// spi writes carry the forced top address bit
		if (spi_wr_evt) begin
			we = 1'b1;
			wa = {`SSHP_SPI_PAGE, spi_wr_addr};
			wd = spi_wr_data;
		end

		// one write port; the lower half and 0x2b are not stored here
		if (we) begin
			if (wa[7]) begin
				r_next.img[wa[6:0]] = wd;
			end
			r_next.wr_stb = 1'b1;
			r_next.wr_addr = wa;
			r_next.wr_data = wd;
		end
	end

	// the whole reference domain in one register
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			r_reg <= rst_state;
		end else begin
			r_reg <= r_next;
		end
	end

	// the enables join both domains; the i2c term leaves a register, the spi term ands drive with the synced 3-wire bit
	// i2c drives only a low level on the data pin; the clock pin is never driven
	assign sdi_out = spi_sdi_out;
	assign sdi_oe = r_reg.sda_oe | spi_sdi_oe;

	// status and strobes straight from the register
	assign reg_wr_stb = r_reg.wr_stb;
	assign reg_wr_addr = r_reg.wr_addr;
	assign reg_wr_data = r_reg.wr_data;
	assign i2c_enabled = r_reg.i2c_en;
	assign spi_locked = r_reg.lock;
	assign spi_mode_11 = r_reg.mode_sy[1];
	assign three_wire_enable = sshp_tw_of(r_reg.img);

endmodule : sshp_host_port

// ===== verilog/sshp_regs.svh
// Purpose: offsets, field positions, reset values and fixed codes of the serial host port
// Assumes: included by bare name wherever a constant is needed
// Notes: definitions only
`ifndef SSHP_REGS_SVH
`define SSHP_REGS_SVH

// fixed upper six bits of the 7-bit target address
`define SSHP_I2C_ADDR_HI 6'h3b

// gas result low status register and its heater stability bit
`define SSHP_REG_GAS_LSB 8'h2b
`define SSHP_HEAT_STAB_BIT 4

// serial port configuration register and its 3-wire enable bit
`define SSHP_REG_SPI_CFG 8'he0
`define SSHP_TW_BIT 0

// top address bit forced by the spi control byte
`define SSHP_SPI_PAGE 1'h1

// register image reset value and read value of unmapped addresses
`define SSHP_IMG_RST 8'h00
`define SSHP_UNMAPPED 8'h00

// idle levels of the select and i2c line synchronisers at reset
`define SSHP_CSB_IDLE 2'h3
`define SSHP_LINE_IDLE 3'h7

// bit counts of one serial byte
`define SSHP_BITS_BYTE 4'h8
`define SSHP_LAST_BIT 4'h7
`define SSHP_BITS_ZERO 4'h0
`define SSHP_BITS_ONE 4'h1

`endif

// ===== verilog/sshp_pkg.sv
// Purpose: types shared by the serial host port modules
// Assumes: constants live in sshp_regs.svh
// Notes: the host port keeps all its state, and the spi link its frame state, in these structs
package sshp_pkg;

	// target side i2c sequencer
	typedef enum logic [2:0] {
		st_idle,
		st_addr,
		st_addr_ack,
		st_rx_byte,
		st_rx_ack,
		st_tx_byte,
		st_tx_ack
	} sshp_i2c_st_t;

	// register image seen by both protocols, upper half of the map
	typedef logic [127:0][7:0] sshp_img_t;

	// state of the reference clock domain
	typedef struct packed {
		logic [1:0] csb_sy;
		logic [2:0] scl_sy;
		logic [2:0] sda_sy;
		logic [1:0] asel_sy;
		logic [2:0] wt_sy;
		logic [1:0] mode_sy;
		logic lock;
		logic i2c_en;
		sshp_i2c_st_t st;
		logic [3:0] bits;
		logic [7:0] sh;
		logic rw;
		logic pair_data;
		logic [7:0] ptr;
		logic sda_oe;
		logic wr_stb;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		sshp_img_t img;
	} sshp_top_t;

	// state of one spi frame, cleared while chip select is high
	typedef struct packed {
		logic [3:0] cnt;
		logic ctrl;
		logic rd;
		logic [6:0] addr;
		logic [6:0] sh;
	} sshp_spi_t;

endpackage : sshp_pkg

// ===== verilog/sshp_spi_link.sv
// Purpose: spi target running on the serial clock from the host
// Assumes: csb_n high clears the frame; image is quasi-static while read
// Notes: writes leave through a toggle plus held address and data
`timescale 1ns/100ps
`include "sshp_regs.svh"

module sshp_spi_link (
	input wire logic sck,
	input wire logic csb_n,
	input wire logic reset,
	input wire logic sdi_in,
	input wire logic tw_en,
	input wire sshp_pkg::sshp_img_t img,
	output logic sdi_out,
	output logic sdi_oe,
	output logic sdo_out,
	output logic sdo_oe,
	output logic wr_tgl,
	output logic [6:0] wr_addr,
	output logic [7:0] wr_data,
	output logic mode_11
);

	sshp_pkg::sshp_spi_t f_reg;
	sshp_pkg::sshp_spi_t f_next;
	logic frame_rst;
	logic [7:0] byte_in;
	logic byte_done;
	logic [1:0] tw_sy;
	logic [7:0] tx_sh;
	logic drive;

	// a frame lives only while chip select is low
	assign frame_rst = reset | csb_n;
	assign byte_in = {f_reg.sh, sdi_in};
	assign byte_done = f_reg.cnt == `SSHP_LAST_BIT;

	// control byte, then data pairs for writes or a read stream
	always_comb begin
		f_next = f_reg;
		f_next.sh = byte_in[6:0];
		f_next.cnt = f_reg.cnt + `SSHP_BITS_ONE;
		if (byte_done) begin
			f_next.cnt = `SSHP_BITS_ZERO;
			if (!f_reg.ctrl) begin
				f_next.ctrl = 1'b1;
				f_next.rd = byte_in[7];
				f_next.addr = byte_in[6:0];
			end else if (!f_reg.rd) begin
				f_next.ctrl = 1'b0;
			end else begin
				f_next.addr = 7'(f_reg.addr + 7'h01);
			end
		end
	end

	// input data taken on the rising edge
	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			f_reg <= '0;
		end else begin
			f_reg <= f_next;
		end
	end

	// write handoff and config sync survive chip select, so the toggle never jumps
	always_ff @(posedge sck or posedge reset) begin
		if (reset) begin
			tw_sy <= 2'h0;
			wr_tgl <= 1'b0;
			wr_addr <= 7'h00;
			wr_data <= 8'h00;
		end else begin
			tw_sy <= {tw_sy[0], tw_en};
			if (byte_done && f_reg.ctrl && !f_reg.rd) begin
				wr_addr <= f_reg.addr;
				wr_data <= byte_in;
				wr_tgl <= ~wr_tgl;
			end
		end
	end

	// output data changes on the falling edge; the idle falling edge of mode 11
	// arrives before any control bit and leaves the line untouched
	always_ff @(negedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			tx_sh <= 8'h00;
			drive <= 1'b0;
		end else if (f_reg.ctrl && f_reg.rd) begin
			drive <= 1'b1;
			if (f_reg.cnt == `SSHP_BITS_ZERO) begin
				tx_sh <= img[f_reg.addr];
			end else begin
				tx_sh <= {tx_sh[6:0], 1'b0};
			end
		end
	end

	// clock level just after chip select falls names the mode
	always_ff @(negedge csb_n or posedge reset) begin
		if (reset) begin
			mode_11 <= 1'b0;
		end else begin
			mode_11 <= sck;
		end
	end

	// 3-wire moves read data onto the shared pin and floats the output pin
	assign sdi_out = tx_sh[7];
	assign sdi_oe = drive & tw_sy[1];
	assign sdo_out = tx_sh[7];
	assign sdo_oe = drive & ~tw_sy[1];

endmodule : sshp_spi_link

// ===== verification/sshp_host_port_assertions.sv
// Purpose: temporal checks on the serial host port pins
// Assumes: bound to sshp_host_port, every check on ref_clk
// Notes: serial bit timing is judged by the bench
`timescale 1ns/100ps
`include "sshp_regs.svh"

module sshp_host_port_chk (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic csb_n,
	input wire logic sck,
	input wire logic sdi_in,
	input wire logic sdi_out,
	input wire logic sdi_oe,
	input wire logic sdo_in,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	input wire logic [7:0] gas_lsb_in,
	input wire logic heater_stable,
	input wire logic reg_wr_stb,
	input wire logic [7:0] reg_wr_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic i2c_enabled,
	input wire logic spi_locked,
	input wire logic spi_mode_11,
	input wire logic three_wire_enable
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// selection and the lock that only reset clears
	lock_blocks_i2c_a: assert property (spi_locked |-> !i2c_enabled)
		else $error("i2c active while locked");
	lock_sticky_a: assert property (spi_locked |=> spi_locked)
		else $error("lock cleared");
	lock_sets_a: assert property (!csb_n [*4] |=> spi_locked)
		else $error("low select did not lock");
	i2c_select_a: assert property ((csb_n && !spi_locked) [*4] |=> i2c_enabled)
		else $error("high select did not enable i2c");
	locked_quiet_a: assert property (spi_locked && csb_n |-> !sdi_oe)
		else $error("locked port drives data");
	// pin drive rules
	open_drain_a: assert property (csb_n && sdi_oe |-> !sdi_out)
		else $error("i2c data driven high");
	four_wire_off_a: assert property (three_wire_enable |-> !sdo_oe)
		else $error("output pin driven in 3-wire");
	csb_float_a: assert property (csb_n |-> !sdo_oe)
		else $error("output driven outside frame");
	// write reporting and what it may cause
	wr_pulse_a: assert property (reg_wr_stb |=> !reg_wr_stb)
		else $error("write strobe longer than a cycle");
	tw_cause_a: assert property ($rose(three_wire_enable) |->
		reg_wr_addr == `SSHP_REG_SPI_CFG && reg_wr_data[`SSHP_TW_BIT])
		else $error("3-wire set without its write");
	mode_cause_a: assert property ($changed(spi_mode_11) |-> spi_locked)
		else $error("mode moved without spi");
	cover property (csb_n && sdi_oe);
	cover property (!csb_n && sdi_oe);
	cover property ($rose(spi_mode_11));
endmodule : sshp_host_port_chk

// ===== verification/sshp_host_model.sv
// Purpose: host controller acting as i2c or spi master
// Assumes: i2c paced on ref_clk, spi clock of 32 ns made here
// Notes: undriven spi data shows the inverse of the host's last bit
`timescale 1ns/100ps

module sshp_host_model (
	input wire logic ref_clk,
	input wire logic sdi_out,
	input wire logic sdi_oe,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	output logic csb_n,
	output logic sck,
	output logic sdi_in,
	output logic sdo_in
);
	logic od = 1'b1;
	logic hv = 1'b1;
	logic hoe = 1'b1;
	logic asel = 1'b0;
	initial csb_n = 1'b1;
	initial sck = 1'b1;
	// open drain with pull-up in i2c, push-pull in spi
	assign sdi_in = od ? (hv & ~(sdi_oe & ~sdi_out)) : (sdi_oe ? sdi_out : (hoe ? hv : ~hv));
	assign sdo_in = sdo_oe ? sdo_out : (od ? asel : ~hv);
	task automatic w(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : w
	// start or repeated start, then stop
	task automatic start();
		od = 1'b1;
		w(6);
		hv <= 1'b1;
		w(6);
		sck <= 1'b1;
		w(6);
		hv <= 1'b0;
		w(6);
		sck <= 1'b0;
	endtask : start
	task automatic stop();
		w(6);
		hv <= 1'b0;
		w(6);
		sck <= 1'b1;
		w(6);
		hv <= 1'b1;
		w(6);
	endtask : stop
	// eight bits then a ninth at level nth; data changes only while the clock is low
	task automatic ibyte(input logic [7:0] b, input logic nth, output logic [7:0] r, output logic ack);
		logic [8:0] v;
		v = {b, nth};
		for (int i = 8; i >= 0; i--) begin
			w(2);
			hv <= v[i];
			w(4);
			sck <= 1'b1;
			w(6);
			if (i > 0) r[i-1] = sdi_in;
			else ack = sdi_in;
			sck <= 1'b0;
		end
	endtask : ibyte
	// the clock rests at its idle level while select moves
	task automatic sopen(input logic m11);
		od = 1'b0;
		sck = m11;
		#20 csb_n = 1'b0;
		#20;
	endtask : sopen
	task automatic sclose(input logic m11);
		sck = m11;
		#20 csb_n = 1'b1;
		#40;
	endtask : sclose
	// drive on the fall, sample on the rise; a 3-wire read frees the shared pin
	task automatic sbyte(input logic [7:0] b, input logic rd, input logic tw, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			hoe = !(rd && tw);
			if (hoe) hv = b[i];
			#16 sck = 1'b1;
			r[i] = tw ? sdi_in : sdo_in;
			#16;
		end
	endtask : sbyte
endmodule : sshp_host_model

// ===== verification/sshp_host_port_tb.sv
// Purpose: self-checking bench of the serial host port
// Assumes: ref_clk 40 MHz; the host model makes the serial clock
// Notes: spi locks i2c out for good, so i2c runs first
`timescale 1ns/100ps
`include "sshp_regs.svh"

module sshp_host_port_tb;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] gas_lsb_in = 8'h00;
	logic heater_stable = 1'b0;
	wire csb_n, sck, sdi_in, sdo_in, sdi_out, sdi_oe, sdo_out, sdo_oe;
	wire reg_wr_stb, i2c_enabled, spi_locked, spi_mode_11, three_wire_enable;
	wire [7:0] reg_wr_addr, reg_wr_data;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [7:0] r, ra, d1, d2, wr_a, wr_d;
	logic [7:0] wr_cnt = 8'h00;
	logic a;
	always #12.5 ref_clk = ~ref_clk;
	sshp_host_port dut (.ref_clk(ref_clk), .reset(reset), .csb_n(csb_n), .sck(sck), .sdi_in(sdi_in),
		.sdi_out(sdi_out), .sdi_oe(sdi_oe), .sdo_in(sdo_in), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
		.gas_lsb_in(gas_lsb_in), .heater_stable(heater_stable), .reg_wr_stb(reg_wr_stb),
		.reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .i2c_enabled(i2c_enabled),
		.spi_locked(spi_locked), .spi_mode_11(spi_mode_11), .three_wire_enable(three_wire_enable));
	sshp_host_model host (.ref_clk(ref_clk), .sdi_out(sdi_out), .sdi_oe(sdi_oe), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .csb_n(csb_n), .sck(sck), .sdi_in(sdi_in), .sdo_in(sdo_in));
	// keep the last reported write
	always @(posedge ref_clk) begin
		if (reg_wr_stb === 1'b1) begin
			wr_cnt <= wr_cnt + 8'h01;
			wr_a <= reg_wr_addr;
			wr_d <= reg_wr_data;
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [7:0] exp_gas(input logic [7:0] g, input logic s);
		exp_gas = g;
		exp_gas[`SSHP_HEAT_STAB_BIT] = s;
	endfunction : exp_gas
	// write-addressed access that leaves the pointer at p
	task automatic point(input logic [7:0] p);
		host.start();
		host.ibyte({`SSHP_I2C_ADDR_HI, host.asel, 1'b0}, 1'b1, r, a);
		check(a, 8'h00);
		host.ibyte(p, 1'b1, r, a);
		check(a, 8'h00);
	endtask : point
	task automatic rd_start(input logic [7:0] p);
		point(p);
		host.start();
		host.ibyte({`SSHP_I2C_ADDR_HI, host.asel, 1'b1}, 1'b1, r, a);
		check(a, 8'h00);
	endtask : rd_start
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// a hang well past the expected 66 us ends the run as a failure
	initial begin
		#400_000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(51386));
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		host.w(4);
		check(i2c_enabled, 8'h01);
		check(spi_locked, 8'h00);
		check(three_wire_enable, 8'h00);
		$display("test reset done");
		ra = 8'h80 | 8'($urandom_range(8'h5e));
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		host.asel <= 1'($urandom);
		host.start();
		host.ibyte({`SSHP_I2C_ADDR_HI, ~host.asel, 1'b0}, 1'b1, r, a);
		check(a, 8'h01);
		host.stop();
		point(ra);
		host.ibyte(d1, 1'b1, r, a);
		check(a, 8'h00);
		host.ibyte(ra + 8'h01, 1'b1, r, a);
		host.ibyte(d2, 1'b1, r, a);
		host.stop();
		check(wr_cnt, 8'h02);
		check(wr_a, ra + 8'h01);
		check(wr_d, d2);
		host.asel <= ~host.asel;
		rd_start(ra);
		host.ibyte(8'hff, 1'b0, r, a);
		check(r, d1);
		host.ibyte(8'hff, 1'b1, r, a);
		check(r, d2);
		host.stop();
		for (int k = 0; k < 2; k++) begin
			gas_lsb_in <= 8'($urandom);
			heater_stable <= k[0];
			rd_start(`SSHP_REG_GAS_LSB);
			host.ibyte(8'hff, 1'b1, r, a);
			check(r, exp_gas(gas_lsb_in, heater_stable));
			host.stop();
		end
		$display("test i2c done");
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		host.sopen(1'b0);
		host.w(5);
		check(spi_locked, 8'h01);
		check(i2c_enabled, 8'h00);
		host.sbyte(ra & 8'h7f, 1'b0, 1'b0, r);
		host.sbyte(d1, 1'b0, 1'b0, r);
		host.sbyte((ra + 8'h01) & 8'h7f, 1'b0, 1'b0, r);
		host.sbyte(d2, 1'b0, 1'b0, r);
		host.sclose(1'b0);
		host.w(6);
		check(wr_cnt, 8'h04);
		check(wr_d, d2);
		check(wr_a, ra + 8'h01);
		check(spi_mode_11, 8'h00);
		host.sopen(1'b1);
		host.sbyte(ra, 1'b0, 1'b0, r);
		host.sbyte(8'h00, 1'b1, 1'b0, r);
		check(r, d1);
		host.sbyte(8'h00, 1'b1, 1'b0, r);
		check(r, d2);
		host.sclose(1'b1);
		host.w(6);
		check(spi_mode_11, 8'h01);
		host.sopen(1'b0);
		host.sbyte(`SSHP_REG_SPI_CFG & 8'h7f, 1'b0, 1'b0, r);
		host.sbyte(8'h01, 1'b0, 1'b0, r);
		host.sclose(1'b0);
		host.w(6);
		check(three_wire_enable, 8'h01);
		check(wr_cnt, 8'h05);
		check(wr_a, `SSHP_REG_SPI_CFG);
		host.sopen(1'b0);
		host.sbyte(ra, 1'b0, 1'b1, r);
		host.sbyte(8'h00, 1'b1, 1'b1, r);
		check(r, d1);
		host.sclose(1'b0);
		$display("test spi done");
		host.start();
		host.ibyte({`SSHP_I2C_ADDR_HI, host.asel, 1'b0}, 1'b1, r, a);
		check(a, 8'h01);
		host.stop();
		$display("test lock done");
		tally_and_finish();
	end
endmodule : sshp_host_port_tb

bind sshp_host_port sshp_host_port_chk chk (.ref_clk(ref_clk), .reset(reset), .csb_n(csb_n), .sck(sck),
	.sdi_in(sdi_in), .sdi_out(sdi_out), .sdi_oe(sdi_oe), .sdo_in(sdo_in), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
	.gas_lsb_in(gas_lsb_in), .heater_stable(heater_stable), .reg_wr_stb(reg_wr_stb),
	.reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .i2c_enabled(i2c_enabled),
	.spi_locked(spi_locked), .spi_mode_11(spi_mode_11), .three_wire_enable(three_wire_enable));
